/* rtl/acps_pkg.sv */
// Shared constants, types and arithmetic for the converter phase and setup block.
package acps_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 7;
    localparam int DEC_W = 12;
    localparam int PIN_W = 6;

    // ==========================================================
    // Register offsets
    localparam logic [6:0] OFS_CH_SETUP = 7'h00;
    localparam logic [6:0] OFS_CH_OFF_MASK = 7'h08;
    localparam logic [6:0] OFS_CH_PHASE = 7'h09;
    localparam logic [6:0] OFS_GLOBAL_ONE = 7'h11;
    localparam logic [6:0] OFS_AUX_DIR = 7'h12;
    localparam logic [6:0] OFS_AUX_DATA = 7'h13;
    localparam logic [6:0] OFS_MUX_SETUP = 7'h14;
    localparam logic [6:0] OFS_BUF_ONE = 7'h15;
    localparam logic [6:0] OFS_BUF_TWO = 7'h16;

    // ==========================================================
    // Field positions
    localparam int GAIN_LSB = 6;
    localparam int REF_SEL_LSB = 6;
    localparam int HIRES_BIT = 6;
    localparam int CM_PD_BIT = 5;
    localparam int IREF_PD_BIT = 4;
    localparam int SAR_PD_BIT = 3;
    localparam int OSC_PD_BIT = 2;
    localparam int BUF_POS_BIT = 4;
    localparam int BUF_NEG_BIT = 3;
    localparam int PRE_POS_BIT = 7;
    localparam int PRE_NEG_BIT = 6;
    localparam int AREG1_BIT = 2;
    localparam int AREG2_BIT = 1;
    localparam int DREG_BIT = 0;
    localparam int PIN_SYNC = 0;
    localparam int PIN_FMT0 = 1;
    localparam int PIN_FMT1 = 2;
    localparam int PIN_AUX = 3;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_GLOBAL_ONE = 8'h58;
    localparam logic [7:0] RST_BUF_ONE = 8'h18;
    localparam logic [7:0] RST_BUF_TWO = 8'hc0;
    localparam logic [5:0] RST_PINS = 6'h01;

    // ==========================================================
    // Modulator clock division per power mode
    localparam logic [3:0] MOD_DIV_HI = 4'h4;
    localparam logic [3:0] MOD_DIV_LP = 4'h8;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        BUF_OFF = 2'b00,
        BUF_ENABLED = 2'b01,
        BUF_PRECHARGED = 2'b10
    } acps_buf_mode_type;

    typedef enum logic [1:0] {
        REF_EXT = 2'b00,
        REF_INT = 2'b01,
        REF_SUPPLY = 2'b10,
        REF_EXT_SWAP = 2'b11
    } acps_ref_sel_type;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_DELAY = 2'b01,
        CH_RUN = 2'b10
    } acps_ch_state_type;

    // ==========================================================
    // Functions
    // Scaling factor for the phase delay, taken from the decimation rate.
    function automatic logic [11:0] phase_factor(input logic [11:0] dec);
        if (dec <= 12'h0ff) return 12'h001;
        else if (dec <= 12'h1ff) return 12'h002;
        else if (dec <= 12'h3ff) return 12'h004;
        else if (dec <= 12'h7ff) return 12'h008;
        else return 12'h010;
    endfunction

    // Stored delay times the factor, clipped below the decimation rate.
    function automatic logic [11:0] phase_effective(input logic [7:0] val, input logic [11:0] dec);
        logic [11:0] prod;
        prod = {4'h0, val} * phase_factor(dec);
        if (dec == 12'h000) return 12'h000;
        else if (prod >= dec) return dec - 12'h001;
        else return prod;
    endfunction

endpackage

/* rtl/acps_phase_scale.sv */
// Rescales a written phase delay so that the product with the factor fits eight bits.
module acps_phase_scale
    import acps_pkg::*;
(
    input wire logic [7:0] i_value,
    input wire logic [11:0] i_dec,
    output logic [7:0] o_stored
);

    logic [11:0] prod;

    // ==========================================================
    // Product and scaling
    always_comb begin
        prod = {4'h0, i_value} * phase_factor(i_dec);
        if (prod <= 12'h0ff) begin
            o_stored = prod[7:0];
        end else if (prod <= 12'h1ff) begin
            o_stored = prod[8:1];
        end else if (prod <= 12'h3ff) begin
            o_stored = prod[9:2];
        end else if (prod <= 12'h7ff) begin
            o_stored = prod[10:3];
        end else begin
            o_stored = prod[11:4];
        end
    end

endmodule

/* rtl/acps_chan_timer.sv */
// One channel's filter start delay and decimation counter.
module acps_chan_timer
    import acps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_mod_en,
    input wire logic i_sync,
    input wire logic [7:0] i_phase,
    input wire logic [11:0] i_dec,
    output logic o_run,
    output logic o_sample
);

    acps_ch_state_type state_r;
    logic [11:0] cnt_r;
    logic [11:0] dec_r;

    // ==========================================================
    // Delay then free running decimation count
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= CH_IDLE;
            cnt_r <= 12'h000;
            dec_r <= 12'h000;
            o_sample <= 1'b0;
        end else begin
            o_sample <= 1'b0;
            if (!i_enable) begin
                state_r <= CH_IDLE;
            end else if (i_sync) begin
                dec_r <= i_dec;
                cnt_r <= phase_effective(i_phase, i_dec);
                state_r <= CH_DELAY;
            end else if (i_mod_en) begin
                unique case (state_r)
                    CH_IDLE: begin
                        cnt_r <= 12'h000;
                    end
                    CH_DELAY: begin
                        if (cnt_r == 12'h000) begin
                            state_r <= CH_RUN;
                        end else begin
                            cnt_r <= cnt_r - 12'h001;
                        end
                    end
                    CH_RUN: begin
                        if (cnt_r >= dec_r - 12'h001) begin
                            cnt_r <= 12'h000;
                            o_sample <= 1'b1;
                        end else begin
                            cnt_r <= cnt_r + 12'h001;
                        end
                    end
                    default: begin
                        state_r <= CH_IDLE;
                    end
                endcase
            end
        end
    end

    assign o_run = (state_r == CH_RUN);

endmodule

/* rtl/acps_top.sv */
// Phase delay, gain, reference, power and auxiliary pin control of the converter array.
//
// Behaviour
// - After sync, each channel's filter start waits its delay in modulator clocks.
// - Delay values are taken only at a sync pulse; later writes wait.
// - Delay is multiplied by 1, 2, 4, 8 or 16 by decimation rate.
// - An effective delay reaching the decimation rate becomes rate minus one.
// - A written delay is stored as value times n, shifted down to fit eight bits.
// - Channel setup bits 7 to 6 pick amplifier gain 1, 2, 4 or 8.
// - Sample rate is clock over four or eight times decimation, by power mode.
// - In serial control mode the mode pins become auxiliary pins.
// - Direction bits 2 to 0 set each auxiliary pin; data register reads and drives.
// - Mux setup bits 7 to 6 pick external, internal, supply or swapped reference.
// - Reference and buffer mode apply to all channels together.
// - Buffer bits 4 and 3 enable, second register bits 7 and 6 precharge.
// - Reference buffers come out of reset precharged.
// - Global setup bit 6 selects high resolution or low power.
// - Global setup bits 5 to 2 power down blocks; a mask disables channels.
// - Second buffer register bits 2 to 0 bypass the three regulators.
// - Register access works only with both format pins high.
module acps_top
    import acps_pkg::*;
#(
    parameter int NUM_AUX = 3
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sync_n,
    input wire logic i_format_pin_zero,
    input wire logic i_format_pin_one,
    input wire logic [DEC_W-1:0] i_decimation,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [NUM_AUX-1:0] i_aux_pins,
    output logic [NUM_AUX-1:0] o_aux_pins,
    output logic [NUM_AUX-1:0] o_aux_pins_oe,
    output logic o_serial_mode,
    output logic o_modulator_clock_en,
    output logic o_high_res,
    output logic [2*NUM_CH-1:0] o_pga_gain,
    output acps_ref_sel_type o_ref_select,
    output acps_buf_mode_type o_refp_buf_mode,
    output acps_buf_mode_type o_refn_buf_mode,
    output logic o_common_mode_buffer_pd,
    output logic o_int_ref_buf_pd,
    output logic o_sar_pd,
    output logic o_osc_pd,
    output logic [NUM_CH-1:0] o_channel_off_mask,
    output logic o_analog_regulator_one_bypass,
    output logic o_analog_regulator_two_bypass,
    output logic o_digital_regulator_bypass,
    output logic o_sync_event,
    output logic [NUM_CH-1:0] o_filter_run,
    output logic [NUM_CH-1:0] o_chan_sample
);

    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_s3_r;
    logic [PIN_W-1:0] pin_stable_r;
    logic [PIN_W-1:0] pin_stable_nxt;
    logic sync_fire;
    logic sync_r;
    logic serial_mode;
    logic wr_ok;
    logic [3:0] mod_cnt_r;
    logic [3:0] mod_div;
    logic mod_en_r;
    logic [7:0] setup_r [NUM_CH];
    logic [7:0] phase_r [NUM_CH];
    logic [7:0] off_mask_r;
    logic [7:0] global_one_r;
    logic [7:0] mux_r;
    logic [7:0] buf_one_r;
    logic [7:0] buf_two_r;
    logic [NUM_AUX-1:0] aux_dir_r;
    logic [NUM_AUX-1:0] aux_out_r;
    logic [NUM_AUX-1:0] aux_in;
    logic [7:0] phase_stored;
    logic [7:0] rdata_nxt;

    // ==========================================================
    // Pin synchronisers
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            pin_stable_nxt[i] = (pin_s2_r[i] == pin_s3_r[i]) ? pin_s3_r[i] : pin_stable_r[i];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pin_meta_r <= RST_PINS;
            pin_s2_r <= RST_PINS;
            pin_s3_r <= RST_PINS;
            pin_stable_r <= RST_PINS;
        end else begin
            pin_meta_r <= {i_aux_pins, i_format_pin_one, i_format_pin_zero, i_sync_n};
            pin_s2_r <= pin_meta_r;
            pin_s3_r <= pin_s2_r;
            pin_stable_r <= pin_stable_nxt;
        end
    end

    // A sync event is the settled falling edge of the active low sync pin.
    assign sync_fire = pin_stable_r[PIN_SYNC] & ~pin_stable_nxt[PIN_SYNC];
    assign serial_mode = pin_stable_r[PIN_FMT0] & pin_stable_r[PIN_FMT1];
    assign wr_ok = i_reg_wr & serial_mode;
    assign aux_in = pin_stable_r[PIN_AUX +: NUM_AUX];

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sync_r <= 1'b0;
        end else begin
            sync_r <= sync_fire;
        end
    end

    // ==========================================================
    // Modulator clock enable
    assign mod_div = global_one_r[HIRES_BIT] ? MOD_DIV_HI : MOD_DIV_LP;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            mod_cnt_r <= 4'h0;
            mod_en_r <= 1'b0;
        end else begin
            mod_en_r <= (mod_cnt_r >= mod_div - 4'h1);
            mod_cnt_r <= (mod_cnt_r >= mod_div - 4'h1) ? 4'h0 : mod_cnt_r + 4'h1;
        end
    end

    // ==========================================================
    // Channel setup and phase delay registers
    acps_phase_scale u_scale (
        .i_value(i_reg_wdata),
        .i_dec(i_decimation),
        .o_stored(phase_stored)
    );

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                setup_r[c] <= RST_BYTE;
                phase_r[c] <= RST_BYTE;
            end
        end else if (wr_ok) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (i_reg_addr == OFS_CH_SETUP + 7'(c)) begin
                    setup_r[c] <= i_reg_wdata;
                end
                if (i_reg_addr == OFS_CH_PHASE + 7'(c)) begin
                    phase_r[c] <= phase_stored;
                end
            end
        end
    end

    // ==========================================================
    // Global, reference and buffer registers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            off_mask_r <= RST_BYTE;
            global_one_r <= RST_GLOBAL_ONE;
            mux_r <= RST_BYTE;
            buf_one_r <= RST_BUF_ONE;
            buf_two_r <= RST_BUF_TWO;
        end else if (wr_ok) begin
            unique case (i_reg_addr)
                OFS_CH_OFF_MASK: begin
                    off_mask_r <= i_reg_wdata;
                end
                OFS_GLOBAL_ONE: begin
                    global_one_r <= i_reg_wdata;
                end
                OFS_MUX_SETUP: begin
                    mux_r <= i_reg_wdata;
                end
                OFS_BUF_ONE: begin
                    buf_one_r <= i_reg_wdata;
                end
                OFS_BUF_TWO: begin
                    buf_two_r <= i_reg_wdata;
                end
                default: begin
                    off_mask_r <= off_mask_r;
                end
            endcase
        end
    end

    // ==========================================================
    // Auxiliary pins
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            aux_dir_r <= '0;
            aux_out_r <= '0;
        end else if (wr_ok) begin
            if (i_reg_addr == OFS_AUX_DIR) begin
                aux_dir_r <= i_reg_wdata[NUM_AUX-1:0];
            end
            if (i_reg_addr == OFS_AUX_DATA) begin
                aux_out_r <= i_reg_wdata[NUM_AUX-1:0];
            end
        end
    end

    assign o_aux_pins = aux_out_r;
    assign o_aux_pins_oe = serial_mode ? aux_dir_r : '0;

    // ==========================================================
    // Register read back
    always_comb begin
        rdata_nxt = 8'h00;
        for (int c = 0; c < NUM_CH; c++) begin
            if (i_reg_addr == OFS_CH_SETUP + 7'(c)) begin
                rdata_nxt = setup_r[c];
            end
            if (i_reg_addr == OFS_CH_PHASE + 7'(c)) begin
                rdata_nxt = phase_r[c];
            end
        end
        unique case (i_reg_addr)
            OFS_CH_OFF_MASK: rdata_nxt = off_mask_r;
            OFS_GLOBAL_ONE: rdata_nxt = global_one_r;
            OFS_AUX_DIR: rdata_nxt = {{(8-NUM_AUX){1'b0}}, aux_dir_r};
            OFS_AUX_DATA: rdata_nxt = {{(8-NUM_AUX){1'b0}}, (aux_dir_r & aux_out_r) | (~aux_dir_r & aux_in)};
            OFS_MUX_SETUP: rdata_nxt = mux_r;
            OFS_BUF_ONE: rdata_nxt = buf_one_r;
            OFS_BUF_TWO: rdata_nxt = buf_two_r;
            default: rdata_nxt = rdata_nxt;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            o_reg_rdata <= (i_reg_rd && serial_mode) ? rdata_nxt : 8'h00;
        end
    end

    // ==========================================================
    // Per channel filter timers
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        acps_chan_timer u_timer (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_enable(~off_mask_r[c]),
            .i_mod_en(mod_en_r),
            .i_sync(sync_r),
            .i_phase(phase_r[c]),
            .i_dec(i_decimation),
            .o_run(o_filter_run[c]),
            .o_sample(o_chan_sample[c])
        );
        assign o_pga_gain[2*c +: 2] = setup_r[c][GAIN_LSB +: 2];
    end

    // ==========================================================
    // Global setting outputs
    assign o_serial_mode = serial_mode;
    assign o_modulator_clock_en = mod_en_r;
    assign o_sync_event = sync_r;
    assign o_high_res = global_one_r[HIRES_BIT];
    assign o_ref_select = acps_ref_sel_type'(mux_r[REF_SEL_LSB +: 2]);
    assign o_refp_buf_mode = !buf_one_r[BUF_POS_BIT] ? BUF_OFF :
        (buf_two_r[PRE_POS_BIT] ? BUF_PRECHARGED : BUF_ENABLED);
    assign o_refn_buf_mode = !buf_one_r[BUF_NEG_BIT] ? BUF_OFF :
        (buf_two_r[PRE_NEG_BIT] ? BUF_PRECHARGED : BUF_ENABLED);
    assign o_common_mode_buffer_pd = global_one_r[CM_PD_BIT];
    assign o_int_ref_buf_pd = global_one_r[IREF_PD_BIT];
    assign o_sar_pd = global_one_r[SAR_PD_BIT];
    assign o_osc_pd = global_one_r[OSC_PD_BIT];
    assign o_channel_off_mask = off_mask_r;
    assign o_analog_regulator_one_bypass = buf_two_r[AREG1_BIT];
    assign o_analog_regulator_two_bypass = buf_two_r[AREG2_BIT];
    assign o_digital_regulator_bypass = buf_two_r[DREG_BIT];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    property p_gain_write;
        wr_ok && i_reg_addr == OFS_CH_SETUP |=> o_pga_gain[1:0] == $past(i_reg_wdata[7:6]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain not taken");

    property p_no_write_pin_mode;
        i_reg_wr && !serial_mode |=> $stable(global_one_r) && $stable(buf_two_r) && $stable(off_mask_r);
    endproperty
    a_no_write_pin_mode: assert property (p_no_write_pin_mode) else $error("write in pin mode");

    property p_power_mode;
        wr_ok && i_reg_addr == OFS_GLOBAL_ONE |=> o_high_res == $past(i_reg_wdata[6]);
    endproperty
    a_power_mode: assert property (p_power_mode) else $error("power mode not taken");

    property p_hires_div;
        mod_en_r && o_high_res ##1 o_high_res [*3] |->
            (!mod_en_r && !$past(mod_en_r) && !$past(mod_en_r, 2)) ##1 mod_en_r;
    endproperty
    a_hires_div: assert property (p_hires_div) else $error("bad modulator divide");

    property p_aux_release;
        !serial_mode |-> o_aux_pins_oe == '0;
    endproperty
    a_aux_release: assert property (p_aux_release) else $error("aux driven in pin mode");

    property p_aux_dir;
        wr_ok && i_reg_addr == OFS_AUX_DIR ##1 serial_mode |-> o_aux_pins_oe == $past(i_reg_wdata[2:0]);
    endproperty
    a_aux_dir: assert property (p_aux_dir) else $error("aux direction wrong");

    property p_phase_small;
        wr_ok && i_reg_addr == OFS_CH_PHASE && i_decimation <= 12'h0ff |=> phase_r[0] == $past(i_reg_wdata);
    endproperty
    a_phase_small: assert property (p_phase_small) else $error("phase store wrong");

    property p_bypass;
        wr_ok && i_reg_addr == OFS_BUF_TWO |=> o_digital_regulator_bypass == $past(i_reg_wdata[0])
            && o_analog_regulator_one_bypass == $past(i_reg_wdata[2]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");

    property p_posbuf_off;
        wr_ok && i_reg_addr == OFS_BUF_ONE && !i_reg_wdata[4] |=> o_refp_buf_mode == BUF_OFF;
    endproperty
    a_posbuf_off: assert property (p_posbuf_off) else $error("buffer not off");

    property p_sync_delay;
        sync_r && !off_mask_r[0] |=> !o_filter_run[0];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("filter ran without delay");

endmodule

/* sim/acps_host_model.sv */
// Host controller model driving the register port and the sync pin.
module acps_host_model
    import acps_pkg::*;
(
    input wire logic i_clk,
    output logic o_wr,
    output logic o_rd,
    output logic [ADDR_W-1:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_sync_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Bus tasks; released lines show the inverse of the last value.
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 7'h7f;
        o_wdata = 8'hff;
        o_sync_n = 1'b1;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
    endtask
    // Sync pulse, long enough for the pin synchroniser.
    task automatic sync_pulse();
        @(posedge i_clk);
        o_sync_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_sync_n <= 1'b1;
    endtask
endmodule

/* sim/test_adc_channel_phase_and_setup.sv */
// Self-checking bench of the converter phase and setup block.
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; $display("BAD %s %0h %0h", nm, ex, got); end end
module test_adc_channel_phase_and_setup
    import acps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic fmt = 1'b1;
    logic [DEC_W-1:0] i_decimation = 12'h014;
    logic [2:0] i_aux_pins = 3'h0;
    logic i_reg_wr, i_reg_rd, i_sync_n, o_reg_rvalid, o_modulator_clock_en, o_high_res;
    logic o_serial_mode, o_sync_event;
    logic [6:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, o_channel_off_mask, o_filter_run, o_chan_sample, prev_run = 8'h00;
    logic [2:0] o_aux_pins, o_aux_pins_oe;
    logic [15:0] o_pga_gain;
    logic o_common_mode_buffer_pd, o_int_ref_buf_pd, o_sar_pd, o_osc_pd;
    logic o_analog_regulator_one_bypass, o_analog_regulator_two_bypass, o_digital_regulator_bypass;
    acps_ref_sel_type o_ref_select;
    acps_buf_mode_type o_refp_buf_mode, o_refn_buf_mode;
    logic [31:0] seed = 32'd84, r;
    int err_total = 0, checks = 0, cyc = 0, t_samp = 0, gap = 0, n_sync = 0, t_run[8];
    int dtab[5] = '{200, 400, 900, 2000, 4000};
    wire [3:0] pd = {o_common_mode_buffer_pd, o_int_ref_buf_pd, o_sar_pd, o_osc_pd};
    wire [2:0] byp = {o_analog_regulator_one_bypass, o_analog_regulator_two_bypass, o_digital_regulator_bypass};
    always #12.5 i_clk = ~i_clk;
    acps_host_model acps_host_model_inst (.i_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
        .o_wdata(i_reg_wdata), .o_sync_n(i_sync_n));
    acps_top acps_top_inst (.i_clk, .i_resetn, .i_sync_n, .i_format_pin_zero(fmt), .i_format_pin_one(fmt),
        .i_decimation, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
        .i_aux_pins, .o_aux_pins, .o_aux_pins_oe, .o_serial_mode, .o_modulator_clock_en, .o_high_res,
        .o_pga_gain, .o_ref_select, .o_refp_buf_mode, .o_refn_buf_mode, .o_common_mode_buffer_pd,
        .o_int_ref_buf_pd, .o_sar_pd, .o_osc_pd, .o_channel_off_mask, .o_analog_regulator_one_bypass,
        .o_analog_regulator_two_bypass, .o_digital_regulator_bypass, .o_sync_event, .o_filter_run,
        .o_chan_sample);
    // ==========================================================
    // Model and helpers.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int stored(int v, int d);
        int p;
        p = v * (d <= 255 ? 1 : d <= 511 ? 2 : d <= 1023 ? 4 : d <= 2047 ? 8 : 16);
        while (p > 255) p = p / 2;
        return p;
    endfunction
    always @(negedge i_clk) begin
        cyc++;
        if (o_sync_event === 1'b1) n_sync++;
        for (int c = 0; c < 8; c++) if (o_filter_run[c] === 1'b1 && prev_run[c] === 1'b0) t_run[c] = cyc;
        prev_run = o_filter_run;
        if (o_chan_sample[0] === 1'b1) begin
            gap = cyc - t_samp;
            t_samp = cyc;
        end
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        acps_host_model_inst.wr(a, d);
        #1;
    endtask
    task automatic rd(input logic [6:0] a);
        acps_host_model_inst.rd(a);
        #1;
        `CHK("rvalid", 1'b1, o_reg_rvalid)
    endtask
    task automatic men_gap(input int exp);
        int a, b;
        a = -1;
        b = -1;
        for (int i = 0; i < 40; i++) begin
            @(posedge i_clk);
            #1;
            if (o_modulator_clock_en === 1'b1 && a >= 0 && b < 0) b = i;
            if (o_modulator_clock_en === 1'b1 && a < 0) a = i;
        end
        `CHK("mod_gap", exp, b - a)
    endtask
    task automatic wait_run();
        repeat (2) @(posedge i_clk);
        for (int i = 0; i < 400 && o_filter_run !== 8'h7f; i++) @(posedge i_clk);
        if (o_filter_run !== 8'h7f) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
        `CHK("high_res", 1'b1, o_high_res)
        `CHK("refp", BUF_PRECHARGED, o_refp_buf_mode)
        `CHK("refn", BUF_PRECHARGED, o_refn_buf_mode)
        `CHK("pd", 4'b0110, pd)
        `CHK("mask0", 8'h00, o_channel_off_mask)
        `CHK("serial", 1'b1, o_serial_mode)
        for (int k = 0; k < 8; k++) begin
            r = {rnd()};
            wr(OFS_CH_SETUP + 7'(k), {2'(k), r[5:0]});
            `CHK("gain", 2'(k), o_pga_gain[2*k +: 2])
            rd(OFS_CH_SETUP + 7'(k));
            `CHK("setup", {2'(k), r[5:0]}, o_reg_rdata)
            wr(OFS_MUX_SETUP, {2'(k), 6'h00});
            `CHK("ref", 2'(k), o_ref_select)
            wr(OFS_BUF_ONE, r[7:0]);
            wr(OFS_BUF_TWO, r[15:8]);
            `CHK("refp", r[4] ? {r[15], ~r[15]} : 2'b00, o_refp_buf_mode)
            `CHK("refn", r[3] ? {r[14], ~r[14]} : 2'b00, o_refn_buf_mode)
            `CHK("bypass", r[10:8], byp)
            wr(OFS_GLOBAL_ONE, {r[23], k[0], r[21:16]});
            `CHK("pd", r[21:18], pd)
            men_gap(k[0] ? 4 : 8);
            wr(OFS_AUX_DIR, r[2:0]);
            `CHK("oe", r[2:0], o_aux_pins_oe)
            wr(OFS_AUX_DATA, r[31:24]);
            `CHK("aux_out", r[26:24], o_aux_pins)
            i_aux_pins <= r[30:28];
            repeat (4) @(posedge i_clk);
            rd(OFS_AUX_DATA);
            `CHK("aux_in", (r[2:0] & r[26:24]) | (~r[2:0] & r[30:28]), o_reg_rdata[2:0])
            i_decimation <= 12'(dtab[k % 5] + r[13:8]);
            wr(OFS_CH_PHASE + 7'(k), r[23:16]);
            rd(OFS_CH_PHASE + 7'(k));
            `CHK("phase", stored(r[23:16], dtab[k % 5] + r[13:8]), o_reg_rdata)
        end
        wr(OFS_GLOBAL_ONE, RST_GLOBAL_ONE);
        i_decimation <= 12'd20;
        wr(OFS_CH_OFF_MASK, 8'h80);
        wr(OFS_CH_PHASE, 8'd0);
        wr(OFS_CH_PHASE + 7'd1, 8'd5);
        wr(OFS_CH_PHASE + 7'd2, 8'd30);
        acps_host_model_inst.sync_pulse();
        wait_run();
        `CHK("delay1", 20, t_run[1] - t_run[0])
        `CHK("delay2", 76, t_run[2] - t_run[0])
        wr(OFS_CH_PHASE + 7'd1, 8'd10);
        repeat (200) @(posedge i_clk);
        `CHK("gap", 80, gap)
        `CHK("run", 8'h7f, o_filter_run)
        acps_host_model_inst.sync_pulse();
        wait_run();
        `CHK("delay1b", 40, t_run[1] - t_run[0])
        `CHK("syncs", 2, n_sync)
        fmt <= 1'b0;
        repeat (6) @(posedge i_clk);
        wr(OFS_CH_OFF_MASK, 8'h00);
        `CHK("mask", 8'h80, o_channel_off_mask)
        rd(OFS_CH_OFF_MASK);
        `CHK("rd_off", 8'h00, o_reg_rdata)
        `CHK("serial_off", 1'b0, o_serial_mode)
        tally_and_finish();
    end
endmodule
